//--- sds_seq.sv
// step/dir front end, microstep position sequencer and interpolator
module sds_seq #(
	parameter int STST_CLKS = sds_pkg::STST_CLKS_DEF
) (
	input wire logic clk, // system clock, 20 MHz
	input wire logic nrst, // async reset, active low
	input wire logic [sds_pkg::ADDR_W-1:0] paddr, // apb address
	input wire logic psel, // apb select
	input wire logic penable, // apb access phase
	input wire logic pwrite, // apb direction
	input wire logic [sds_pkg::DATA_W-1:0] pwdata, // apb write data
	output logic [sds_pkg::DATA_W-1:0] prdata, // apb read data
	output logic pready, // apb ready, zero wait
	output logic pslverr, // apb error on unmapped address
	input wire logic step_pin, // step pulse from controller
	input wire logic dir_pin, // direction from controller
	output logic [sds_pkg::TBL_W-1:0] mscnt, // table position
	output logic [sds_pkg::CUR_W-1:0] cur_scale, // selected current scale
	output logic standstill // standstill flag
);
	localparam int TW = sds_pkg::TBL_W;
	localparam int IVL_W = $clog2(STST_CLKS) + 1;
	localparam int PER_W = IVL_W - sds_pkg::IP_SHIFT;
	localparam int REM_W = sds_pkg::IP_SHIFT + 1;
	localparam int DW = sds_pkg::DATA_W;

	function automatic logic [TW-1:0] width_of(input logic [3:0] m);
		logic [3:0] e;
		e = (m > sds_pkg::MRES_FULL) ? sds_pkg::MRES_FULL : m;
		return TW'(1) << e;
	endfunction

	function automatic logic [TW-1:0] snap(input logic [TW-1:0] p,
			input logic [TW-1:0] w);
		logic [TW-1:0] r;
		r = p;
		if (w != TW'(1))
			r = (p & ~(w - TW'(1))) | (w >> 1);
		return r;
	endfunction

	function automatic logic mapped(input logic [sds_pkg::ADDR_W-1:0] a);
		return (a == sds_pkg::ADDR_CHOP) || (a == sds_pkg::ADDR_CUR) ||
			(a == sds_pkg::ADDR_STAT);
	endfunction

	// pin synchronisation
	logic [1:0] pins_s;
	logic step_s;
	logic dir_s;

	sds_sync2 #(.W(2)) u_sync (
		.clk(clk),
		.nrst(nrst),
		.din({dir_pin, step_pin}),
		.dout(pins_s)
	);
	assign step_s = pins_s[0];
	assign dir_s = pins_s[1];

	// register file
	sds_pkg::sds_chop_s chop_ff;
	sds_pkg::sds_chop_s nxt_chop;
	sds_pkg::sds_cur_s cur_ff;
	sds_pkg::sds_cur_s nxt_cur;
	logic [DW-1:0] prdata_ff;
	logic [DW-1:0] nxt_prdata;
	logic setup_ph;
	logic access_ph;

	// sequencer state
	logic [TW-1:0] target_ff;
	logic [TW-1:0] nxt_target;
	logic [TW-1:0] cnt_ff;
	logic [TW-1:0] nxt_cnt;
	logic [REM_W-1:0] rem_ff;
	logic [REM_W-1:0] nxt_rem;
	logic dir_ip_ff;
	logic nxt_dir_ip;
	sds_pkg::sds_ip_e ip_st_ff;
	sds_pkg::sds_ip_e nxt_ip_st;
	logic [3:0] mres_prev_ff;
	logic [3:0] nxt_mres_prev;
	logic step_d_ff;
	logic [IVL_W-1:0] ivl_ff;
	logic [IVL_W-1:0] nxt_ivl;
	logic stst_ff;
	logic nxt_stst;
	logic [sds_pkg::CUR_W-1:0] cur_out_ff;
	logic [sds_pkg::CUR_W-1:0] nxt_cur_out;

	logic act;
	logic [TW-1:0] wid;
	logic coarser;
	logic interp;
	logic ivl_cap;
	logic [TW-1:0] base;
	logic [PER_W-1:0] per_val;
	logic tick;

	assign setup_ph = psel && !penable;
	assign access_ph = psel && penable;
	assign pready = 1'b1;
	assign pslverr = access_ph && !mapped(paddr);
	assign prdata = prdata_ff;

	always_comb begin
		nxt_chop = chop_ff;
		nxt_cur = cur_ff;
		nxt_prdata = prdata_ff;
		if (access_ph && pwrite) begin
			case (paddr)
			sds_pkg::ADDR_CHOP: begin
				nxt_chop.dedge = pwdata[sds_pkg::CHOP_DEDGE_BIT];
				nxt_chop.intpol = pwdata[sds_pkg::CHOP_INTPOL_BIT];
				nxt_chop.mres = pwdata[sds_pkg::CHOP_MRES_LSB +:
					sds_pkg::MRES_W];
			end
			sds_pkg::ADDR_CUR: begin
				nxt_cur.hold = pwdata[sds_pkg::CUR_HOLD_LSB +: sds_pkg::CUR_W];
				nxt_cur.run = pwdata[sds_pkg::CUR_RUN_LSB +: sds_pkg::CUR_W];
			end
			default: begin
			end
			endcase
		end
		// read data is captured in the setup cycle so it comes from a flop
		if (setup_ph && !pwrite) begin
			nxt_prdata = '0;
			case (paddr)
			sds_pkg::ADDR_CHOP: begin
				nxt_prdata[sds_pkg::CHOP_DEDGE_BIT] = chop_ff.dedge;
				nxt_prdata[sds_pkg::CHOP_INTPOL_BIT] = chop_ff.intpol;
				nxt_prdata[sds_pkg::CHOP_MRES_LSB +: sds_pkg::MRES_W] =
					chop_ff.mres;
			end
			sds_pkg::ADDR_CUR: begin
				nxt_prdata[sds_pkg::CUR_HOLD_LSB +: sds_pkg::CUR_W] = cur_ff.hold;
				nxt_prdata[sds_pkg::CUR_RUN_LSB +: sds_pkg::CUR_W] = cur_ff.run;
			end
			sds_pkg::ADDR_STAT: begin
				nxt_prdata[sds_pkg::STAT_MSCNT_LSB +: TW] = cnt_ff;
				nxt_prdata[sds_pkg::STAT_STST_BIT] = stst_ff;
				nxt_prdata[sds_pkg::STAT_CUR_LSB +: sds_pkg::CUR_W] = cur_out_ff;
			end
			default: begin
			end
			endcase
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			chop_ff <= '{mres: sds_pkg::MRES_RST, intpol: 1'b0, dedge: 1'b0};
			cur_ff <= '{run: sds_pkg::RUN_RST, hold: sds_pkg::HOLD_RST};
			prdata_ff <= '0;
		end else begin
			chop_ff <= nxt_chop;
			cur_ff <= nxt_cur;
			prdata_ff <= nxt_prdata;
		end
	end

	// edge detect on the synchronised step level only
	assign act = (step_s && !step_d_ff) ||
		(chop_ff.dedge && !step_s && step_d_ff);
	assign wid = width_of(chop_ff.mres);
	assign coarser = wid > width_of(mres_prev_ff);
	assign interp = chop_ff.intpol && (wid != TW'(1));
	assign ivl_cap = ivl_ff == IVL_W'(STST_CLKS);
	assign base = coarser ? snap(target_ff, wid) : target_ff;
	// previous interval split into 256 parts, never below one clock
	assign per_val = (ivl_ff[IVL_W-1:sds_pkg::IP_SHIFT] == '0) ? PER_W'(1) :
		ivl_ff[IVL_W-1:sds_pkg::IP_SHIFT];

	sds_utick #(.PW(PER_W)) u_tick (
		.clk(clk),
		.nrst(nrst),
		.load(act && interp),
		.period(per_val),
		.run(ip_st_ff == sds_pkg::IP_RUN),
		.tick(tick)
	);

	always_comb begin
		nxt_target = base;
		nxt_cnt = cnt_ff;
		nxt_rem = rem_ff;
		nxt_dir_ip = dir_ip_ff;
		nxt_ip_st = ip_st_ff;
		nxt_mres_prev = chop_ff.mres;
		nxt_ivl = ivl_cap ? ivl_ff : ivl_ff + IVL_W'(1);
		nxt_stst = stst_ff || ivl_cap;
		nxt_cur_out = stst_ff ? cur_ff.hold : cur_ff.run;
		if (coarser) begin
			nxt_cnt = base;
			nxt_rem = '0;
			nxt_ip_st = sds_pkg::IP_IDLE;
		end
		if (act) begin
			nxt_ivl = '0;
			nxt_stst = 1'b0;
			nxt_dir_ip = dir_s;
			// 10-bit arithmetic wraps around the electrical turn
			nxt_target = dir_s ? base - wid : base + wid;
			if (interp) begin
				// unfinished microsteps of the slower period are dropped
				nxt_cnt = base;
				nxt_rem = REM_W'(wid);
				nxt_ip_st = sds_pkg::IP_RUN;
			end else begin
				nxt_cnt = nxt_target;
				nxt_rem = '0;
				nxt_ip_st = sds_pkg::IP_IDLE;
			end
		end else if (!coarser) begin
			case (ip_st_ff)
			sds_pkg::IP_IDLE: begin
				nxt_cnt = target_ff;
			end
			sds_pkg::IP_RUN: begin
				if (!chop_ff.intpol) begin
					nxt_cnt = target_ff;
					nxt_rem = '0;
					nxt_ip_st = sds_pkg::IP_IDLE;
				end else if (tick) begin
					nxt_cnt = dir_ip_ff ? cnt_ff - TW'(1) : cnt_ff + TW'(1);
					nxt_rem = rem_ff - REM_W'(1);
					if (rem_ff == REM_W'(1))
						nxt_ip_st = sds_pkg::IP_IDLE;
				end
			end
			default: begin
				nxt_ip_st = sds_pkg::IP_IDLE;
			end
			endcase
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			target_ff <= sds_pkg::POS_RST;
			cnt_ff <= sds_pkg::POS_RST;
			rem_ff <= '0;
			dir_ip_ff <= 1'b0;
			ip_st_ff <= sds_pkg::IP_IDLE;
			mres_prev_ff <= sds_pkg::MRES_RST;
			step_d_ff <= 1'b0;
			ivl_ff <= '0;
			stst_ff <= 1'b0;
			cur_out_ff <= sds_pkg::RUN_RST;
		end else begin
			target_ff <= nxt_target;
			cnt_ff <= nxt_cnt;
			rem_ff <= nxt_rem;
			dir_ip_ff <= nxt_dir_ip;
			ip_st_ff <= nxt_ip_st;
			mres_prev_ff <= nxt_mres_prev;
			step_d_ff <= step_s;
			ivl_ff <= nxt_ivl;
			stst_ff <= nxt_stst;
			cur_out_ff <= nxt_cur_out;
		end
	end

	assign mscnt = cnt_ff;
	assign cur_scale = cur_out_ff;
	assign standstill = stst_ff;

	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);

	a_step_sync: assert property (
		act && step_s |-> $past(step_pin, 2) && !$past(step_pin, 3))
		else $error("step edge not from two-stage synchronised pin");
	a_fall_ignored: assert property (
		!chop_ff.dedge && !step_s && step_d_ff && !coarser |=>
			target_ff == $past(target_ff))
		else $error("falling edge counted without dedge");
	a_dir_add: assert property (
		act && !dir_s && !coarser |=>
			target_ff == $past(target_ff) + $past(wid))
		else $error("dir low did not add step width");
	a_dir_sub: assert property (
		act && dir_s && !coarser |=>
			target_ff == $past(target_ff) - $past(wid))
		else $error("dir high did not subtract step width");
	a_full_grid: assert property (
		chop_ff.mres == sds_pkg::MRES_FULL &&
			mres_prev_ff == sds_pkg::MRES_FULL |->
			target_ff[7:0] == 8'h80)
		else $error("full step off the 128 + 256k grid");
	a_snap_grid: assert property (
		coarser |=> (target_ff & ($past(wid) - TW'(1))) ==
			($past(wid) >> 1) || $past(wid) == TW'(1))
		else $error("coarser resolution not snapped to centre");
	a_ip_count: assert property (
		act && interp |=> rem_ff == REM_W'($past(wid)) &&
			ip_st_ff == sds_pkg::IP_RUN)
		else $error("interpolator loaded wrong microstep count");
	a_ip_off: assert property (
		!chop_ff.intpol ##1 !chop_ff.intpol |-> ip_st_ff == sds_pkg::IP_IDLE)
		else $error("interpolator running while disabled");
	a_stst_set: assert property (
		ivl_cap && !act |=> stst_ff)
		else $error("standstill not flagged at interval cap");
	a_stst_clr: assert property (
		act |=> !stst_ff ##1 cur_out_ff == $past(cur_ff.run))
		else $error("step edge did not clear standstill");
	a_hold_cur: assert property (
		stst_ff ##1 stst_ff |-> cur_out_ff == $past(cur_ff.hold))
		else $error("hold current not selected at standstill");
endmodule

//--- sds_pkg.sv
// constants, field layout and types for the step/dir microstep sequencer
// Notes on behaviour
// - dedge set makes both step edges active; clear means rising edges only.
// - step and dir pins are synchronised to clk before use.
// - position indexes a 1024 entry table spanning four full steps.
// - active edge adds step width when dir low, subtracts when dir high.
// - step width is 1 at finest resolution, doubling up to 256 at full step.
// - resolution may change anytime; coarser snaps to nearest valid spot.
// - full step visits 128, 384, 640, 896, moving 256 per step.
// - half step positions start at 64, spaced 128 apart.
// - quarter step positions start at 32, spaced 64 apart.
// - interpolation makes as many microsteps per edge as the step width, timed by last interval.
// - interpolated microsteps per input step run from 2 to 256.
// - interpolation works only while the interpolation enable bit is set.
// - microstep period is the previous step period divided into 256 parts.
// - step interval capped at 2^20 clocks; slower input sets standstill flag.
// - standstill switches the current output from run to hold scale.
// - next active step edge clears the standstill flag.
// - faster rate adopted a period later; pending microsteps may be skipped.
package sds_pkg;
	localparam int TBL_W = 10;
	localparam int MRES_W = 4;
	localparam logic [3:0] MRES_FULL = 4'h8;
	localparam int CUR_W = 5;
	localparam int STST_CLKS_DEF = 1048576;
	localparam int IP_SHIFT = 8;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam logic [7:0] ADDR_CHOP = 8'h00;
	localparam logic [7:0] ADDR_CUR = 8'h04;
	localparam logic [7:0] ADDR_STAT = 8'h08;
	localparam int CHOP_DEDGE_BIT = 0;
	localparam int CHOP_INTPOL_BIT = 1;
	localparam int CHOP_MRES_LSB = 4;
	localparam int CUR_HOLD_LSB = 0;
	localparam int CUR_RUN_LSB = 8;
	localparam int STAT_MSCNT_LSB = 0;
	localparam int STAT_STST_BIT = 16;
	localparam int STAT_CUR_LSB = 24;
	localparam logic [3:0] MRES_RST = 4'h0;
	localparam logic [4:0] HOLD_RST = 5'h08;
	localparam logic [4:0] RUN_RST = 5'h1f;
	localparam logic [9:0] POS_RST = 10'h000;

	typedef struct packed {
		logic [MRES_W-1:0] mres;
		logic intpol;
		logic dedge;
	} sds_chop_s;

	typedef struct packed {
		logic [CUR_W-1:0] run;
		logic [CUR_W-1:0] hold;
	} sds_cur_s;

	typedef enum logic [1:0] {
		IP_IDLE = 2'b01,
		IP_RUN = 2'b10
	} sds_ip_e;
endpackage

//--- sds_sync2.sv
// two flip-flop synchroniser for pin inputs
module sds_sync2 #(
	parameter int W = 2
) (
	input wire logic clk, // system clock
	input wire logic nrst, // async reset, active low
	input wire logic [W-1:0] din, // asynchronous pins
	output logic [W-1:0] dout // synchronised levels
);
	logic [W-1:0] meta_ff;
	logic [W-1:0] sync_ff;

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			meta_ff <= '0;
			sync_ff <= '0;
		end else begin
			meta_ff <= din;
			sync_ff <= meta_ff;
		end
	end

	assign dout = sync_ff;
endmodule

//--- sds_utick.sv
// microstep period timer: reloads on each step edge, ticks once per period
module sds_utick #(
	parameter int PW = 13
) (
	input wire logic clk, // system clock
	input wire logic nrst, // async reset, active low
	input wire logic load, // step edge: take a new period
	input wire logic [PW-1:0] period, // clocks per microstep, at least 1
	input wire logic run, // microsteps pending
	output logic tick // one-cycle microstep strobe
);
	logic [PW-1:0] cnt_ff;
	logic [PW-1:0] nxt_cnt;
	logic [PW-1:0] per_ff;
	logic [PW-1:0] nxt_per;

	assign tick = run && !load && (cnt_ff == PW'(1));

	always_comb begin
		nxt_cnt = cnt_ff;
		nxt_per = per_ff;
		if (load) begin
			nxt_cnt = period;
			nxt_per = period;
		end else if (run) begin
			nxt_cnt = (cnt_ff <= PW'(1)) ? per_ff : cnt_ff - PW'(1);
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			cnt_ff <= '0;
			per_ff <= '0;
		end else begin
			cnt_ff <= nxt_cnt;
			per_ff <= nxt_per;
		end
	end
endmodule

//--- sds_ctl_model.sv
// behavioural step/dir controller: bursts of equal-duty step pulses
module sds_ctl_model (
	input wire logic clk, // system clock
	input wire logic go, // start a burst
	input wire logic dir_req, // direction for the burst
	input wire logic [7:0] n, // pulses in the burst
	input wire logic [15:0] half, // clocks per pulse half, at least 2
	output logic step_pin, // step pulse, low between bursts
	output logic dir_pin, // direction level
	output logic busy // burst in progress
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		step_pin = 1'b0;
		dir_pin = 1'b0;
		busy = 1'b0;
		forever begin
			@(posedge clk);
			if (go) begin
				busy <= 1'b1;
				// direction settles well ahead of the first edge
				dir_pin <= dir_req;
				repeat (half) @(posedge clk);
				// equal halves at one rate, so dedge and interpolation stay clean
				repeat (n) begin
					step_pin <= 1'b1;
					repeat (half) @(posedge clk);
					step_pin <= 1'b0;
					repeat (half) @(posedge clk);
				end
				busy <= 1'b0;
			end
		end
	end
endmodule

//--- sds_seq_tb.sv
// self-checking testbench for the step/dir microstep sequencer
module sds_seq_tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk, nrst, psel, penable, pwrite, pready, pslverr, err;
	logic [7:0] paddr, n_req;
	logic [31:0] pwdata, prdata, rd;
	logic step_pin, dir_pin, standstill, go, dir_req, busy;
	logic [9:0] mscnt;
	logic [4:0] cur_scale;
	logic [15:0] half;
	int n_mismatch, checks_done;

	// short standstill span keeps the run brief
	sds_seq #(.STST_CLKS(4096)) dut (.clk(clk), .nrst(nrst),
		.paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .step_pin(step_pin), .dir_pin(dir_pin),
		.mscnt(mscnt), .cur_scale(cur_scale), .standstill(standstill));
	sds_ctl_model ctl (.clk(clk), .go(go), .dir_req(dir_req), .n(n_req),
		.half(half), .step_pin(step_pin), .dir_pin(dir_pin), .busy(busy));

	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	task automatic give_verdict();
		if (n_mismatch == 0 && checks_done > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	task automatic chk(input string what, input logic [31:0] e,
		input logic [31:0] g);
		checks_done++;
		if (g !== e) begin
			n_mismatch++;
			$display("Error %s expected %h seen %h", what, e, g);
		end
	endtask

	task automatic pos(input logic [9:0] e);
		chk("mscnt", {22'h00_0000, e}, {22'h00_0000, mscnt});
	endtask

	// one apb transfer; read data and error taken at the ready edge
	task automatic apb(input logic wr, input logic [7:0] a,
		input logic [31:0] d);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		// no wait count assumed: only the watchdog ends a stuck transfer
		do begin
			@(posedge clk);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask

	task automatic pulses(input logic [7:0] n, input logic dr,
		input logic [15:0] h);
		go <= 1'b1;
		n_req <= n;
		dir_req <= dr;
		half <= h;
		do begin
			@(posedge clk);
		end while (busy !== 1'b1);
		go <= 1'b0;
		do begin
			@(posedge clk);
		end while (busy !== 1'b0);
		repeat (8) @(posedge clk);
	endtask

	initial begin
		nrst = 1'b0;
		{psel, penable, pwrite, go, dir_req} = 5'h00;
		paddr = 8'h00;
		pwdata = 32'h0000_0000;
		n_req = 8'h00;
		half = 16'h0002;
		n_mismatch = 0;
		checks_done = 0;
		repeat (4) @(posedge clk);
		nrst <= 1'b1;
		@(posedge clk);
		apb(1'b0, sds_pkg::ADDR_CHOP, 32'h0000_0000);
		chk("chop", 32'h0000_0000, rd);
		chk("slverr", 32'h0000_0000, {31'h0000_0000, err});
		apb(1'b0, sds_pkg::ADDR_CUR, 32'h0000_0000);
		chk("cur", 32'h0000_1f08, rd);
		apb(1'b0, sds_pkg::ADDR_STAT, 32'h0000_0000);
		chk("stat", 32'h1f00_0000, rd);
		apb(1'b0, 8'h0c, 32'h0000_0000);
		chk("slverr", 32'h0000_0001, {31'h0000_0000, err});
		pulses(8'h03, 1'b0, 16'h0002);
		pos(10'h003);
		pulses(8'h05, 1'b1, 16'h0002);
		pos(10'h3fe);
		apb(1'b1, sds_pkg::ADDR_CHOP, 32'h0000_0060);
		repeat (2) @(posedge clk);
		pos(10'h3e0);
		pulses(8'h01, 1'b0, 16'h0002);
		pos(10'h020);
		apb(1'b1, sds_pkg::ADDR_CHOP, 32'h0000_0070);
		repeat (2) @(posedge clk);
		pos(10'h040);
		pulses(8'h01, 1'b0, 16'h0002);
		pos(10'h0c0);
		apb(1'b1, sds_pkg::ADDR_CHOP, 32'h0000_0080);
		repeat (2) @(posedge clk);
		pos(10'h080);
		pulses(8'h03, 1'b0, 16'h0002);
		pos(10'h380);
		pulses(8'h01, 1'b0, 16'h0002);
		pos(10'h080);
		pulses(8'h01, 1'b1, 16'h0002);
		pos(10'h380);
		apb(1'b1, sds_pkg::ADDR_CHOP, 32'h0000_0081);
		pulses(8'h01, 1'b0, 16'h0002);
		pos(10'h180);
		apb(1'b1, sds_pkg::ADDR_CUR, 32'h0000_1503);
		apb(1'b0, sds_pkg::ADDR_CUR, 32'h0000_0000);
		chk("cur", 32'h0000_1503, rd);
		repeat (3990) @(posedge clk);
		chk("stst", 32'h0000_0000, {31'h0000_0000, standstill});
		repeat (200) @(posedge clk);
		chk("stst", 32'h0000_0001, {31'h0000_0000, standstill});
		chk("cur_scale", 32'h0000_0003, {27'h000_0000, cur_scale});
		pulses(8'h01, 1'b0, 16'h0002);
		chk("stst", 32'h0000_0000, {31'h0000_0000, standstill});
		chk("cur_scale", 32'h0000_0015, {27'h000_0000, cur_scale});
		pos(10'h380);
		// interpolated full steps: 256 microsteps of one entry each
		apb(1'b1, sds_pkg::ADDR_CHOP, 32'h0000_0082);
		pulses(8'h03, 1'b0, 16'h0500);
		repeat (300) @(posedge clk);
		pos(10'h280);
		pulses(8'h01, 1'b0, 16'h0280);
		chk("mid", 32'h0000_0001,
			{31'h0000_0000, mscnt > 10'h280 && mscnt < 10'h380});
		repeat (3500) @(posedge clk);
		pos(10'h380);
		give_verdict();
	end

	// the whole sequence needs about 19000 cycles
	initial begin
		repeat (60000) @(posedge clk);
		n_mismatch++;
		give_verdict();
	end
endmodule
